/* rtl/asr_pkg.sv */
`default_nettype none
package asr_pkg;
  // ==========================================================
  // Register map and field layout
  localparam logic [7:0] ASR_PRIMARY_CLOCK_CONFIG_ADDR   = 8'h32;
  localparam logic [7:0] ASR_SECONDARY_CLOCK_CONFIG_ADDR = 8'h33;
  localparam logic [7:0] ASR_PRIMARY_CLOCK_CONFIG_RESET   = 8'h00;
  localparam logic [7:0] ASR_SECONDARY_CLOCK_CONFIG_RESET = 8'h00;
  localparam int ASR_RATE_CODE_MSB = 7;
  localparam int ASR_RATE_CODE_LSB = 2;
  localparam int ASR_TOL_SEL_BIT   = 1;
  localparam int ASR_CUSTOM_BIT    = 0;
  // Bit 0 of the secondary register is reserved and reads as zero
  localparam logic [7:0] ASR_SECONDARY_WRITE_MASK = 8'hFE;
  localparam logic [7:0] ASR_UNMAPPED_READ        = 8'h00;

  // ==========================================================
  // Sample-rate codes
  localparam int         ASR_CODE_W    = 6;
  localparam int         ASR_RATE_W    = 20;
  localparam logic [5:0] ASR_CODE_AUTO = 6'h00;
  localparam logic [5:0] ASR_CODE_MAX  = 6'h28;
  localparam int         ASR_NUM_CODES = 41;
  localparam int         ASR_NUM_IFACE = 2;
  localparam int         ASR_PRIMARY   = 0;
  localparam int         ASR_SECONDARY = 1;

  // Tolerance in percent for auto detection
  localparam logic [27:0] ASR_TOL_NARROW_PCT = 28'h0000001;
  localparam logic [27:0] ASR_TOL_WIDE_PCT   = 28'h0000005;
  localparam logic [27:0] ASR_PCT_SCALE      = 28'h0000064;

  // Index 0 is the auto code and has no window
  localparam logic [19:0] ASR_NOM_RATE [ASR_NUM_CODES] = '{
    0, 768000, 614400, 512000, 438857, 384000, 341333, 307200, 256000, 219429, 192000,
    170667, 153600, 128000, 109714, 96000, 85333, 76800, 64000, 54857, 48000,
    42667, 38400, 32000, 27429, 24000, 21333, 19200, 16000, 13714, 12000,
    10667, 9600, 8000, 6857, 6000, 5333, 4800, 4000, 3429, 3000};
  localparam logic [19:0] ASR_MIN_RATE [ASR_NUM_CODES] = '{
    0, 670320, 536256, 446880, 383040, 335160, 297920, 268128, 223440, 191520, 167580,
    148960, 134064, 111720, 95760, 83790, 74480, 67032, 55860, 47880, 41895,
    37240, 33516, 27930, 23940, 20947, 18620, 16758, 13965, 11970, 10473,
    9310, 8379, 6982, 5985, 5236, 4655, 4189, 3491, 2992, 2618};
  localparam logic [19:0] ASR_MAX_RATE [ASR_NUM_CODES] = '{
    0, 791040, 632832, 527360, 452022, 395520, 351573, 316416, 263680, 226011, 197760,
    175786, 158208, 131840, 113005, 98880, 87893, 79104, 65920, 56502, 49440,
    43946, 39552, 32960, 28251, 24720, 21973, 19776, 16480, 14125, 12360,
    10986, 9888, 8240, 7062, 6180, 5493, 4944, 4120, 3531, 3090};

  // ==========================================================
  // Frame-rate measurement gate
  localparam int ASR_CLK_HZ       = 25000000;
  localparam int ASR_GATE_TIME_MS = 1000;
  localparam int ASR_GATE_CYCLES  = (ASR_CLK_HZ / 1000) * ASR_GATE_TIME_MS;
  localparam int ASR_RATE_SCALE   = 1000 / ASR_GATE_TIME_MS;
endpackage
`default_nettype wire

/* rtl/asr_rate_meter.sv */
`timescale 1ns/10ps
`default_nettype none
module asr_rate_meter #(
  parameter int RATE_W     = 20,
  parameter int RATE_SCALE = 1
) (
  input  wire logic              ref_clk_in,
  input  wire logic              rst_b_in,
  input  wire logic              fsync_in,
  input  wire logic              gate_in,
  output logic [RATE_W-1:0]      rate_out,
  output logic                   done_out
);
  // ==========================================================
  // Synchroniser and edge counter
  logic              sync_a;
  logic              sync_b;
  logic              sync_c;
  logic [RATE_W-1:0] edge_cnt;
  logic [RATE_W-1:0] next_edge_cnt;
  logic [RATE_W-1:0] next_rate;
  logic              rise;

  assign rise = sync_b & ~sync_c;

  always_comb begin
    next_edge_cnt = edge_cnt;
    next_rate     = rate_out;
    if (gate_in) begin
      // Count saturates rather than wraps, but the scaled rate is cut to RATE_W bits and can wrap when RATE_SCALE exceeds 1
      next_rate     = RATE_W'(edge_cnt * RATE_W'(RATE_SCALE));
      next_edge_cnt = rise ? RATE_W'(1) : '0;
    end else if (rise && (edge_cnt != '1)) begin
      next_edge_cnt = RATE_W'(edge_cnt + RATE_W'(1));
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (!rst_b_in) begin
      sync_a   <= 1'b0;
      sync_b   <= 1'b0;
      sync_c   <= 1'b0;
      edge_cnt <= '0;
      rate_out <= '0;
      done_out <= 1'b0;
    end else begin
      sync_a   <= fsync_in;
      sync_b   <= sync_a;
      sync_c   <= sync_b;
      edge_cnt <= next_edge_cnt;
      rate_out <= next_rate;
      done_out <= gate_in;
    end
  end
endmodule
`default_nettype wire

/* rtl/asr_sample_rate_config.sv */
// Overview of operation
// - Primary register bits 7..2 hold primary rate code; zero means auto detect.
// - Codes 1 to 40 each give a nominal rate and an accepted window.
// - Primary tolerance bit picks 1% when clear, 5% when set, in auto mode.
// - Primary bit 0 clear means automatic clocks; set means software sets dividers.
// - Secondary register bits 7..2 hold secondary rate code, same table, zero auto.
// - Secondary bit 1 picks 1% or 5% auto tolerance for standard rates.
// - Secondary bit 0 reads zero; software writes only zero there.
// - Both registers reset to zero: auto rates, 1% tolerance, auto clocking.
`timescale 1ns/10ps
`default_nettype none
module asr_sample_rate_config #(
  parameter int GATE_CYCLES = asr_pkg::ASR_GATE_CYCLES,
  parameter int RATE_SCALE  = asr_pkg::ASR_RATE_SCALE
) (
  input  wire logic                          ref_clk_in,
  input  wire logic                          rst_b_in,
  input  wire logic [7:0]                    reg_addr_in,
  input  wire logic                          reg_wr_in,
  input  wire logic [7:0]                    reg_wdata_in,
  input  wire logic                          reg_rd_in,
  output logic [7:0]                         reg_rdata_out,
  input  wire logic                          primary_fsync_in,
  input  wire logic                          secondary_fsync_in,
  output logic [asr_pkg::ASR_CODE_W-1:0]     primary_rate_code_out,
  output logic                               primary_rate_tolerance_sel_out,
  output logic                               auto_clk_cfg_en_out,
  output logic [asr_pkg::ASR_CODE_W-1:0]     secondary_rate_code_out,
  output logic                               secondary_rate_tolerance_sel_out,
  output logic [asr_pkg::ASR_RATE_W-1:0]     primary_measured_rate_out,
  output logic [asr_pkg::ASR_RATE_W-1:0]     secondary_measured_rate_out,
  output logic [asr_pkg::ASR_CODE_W-1:0]     primary_detected_code_out,
  output logic [asr_pkg::ASR_CODE_W-1:0]     secondary_detected_code_out,
  output logic                               primary_rate_valid_out,
  output logic                               secondary_rate_valid_out,
  output logic                               primary_rate_invalid_out,
  output logic                               secondary_rate_invalid_out
);
  import asr_pkg::*;

  // ==========================================================
  // Register file
  logic [7:0] primary_clock_config;
  logic [7:0] secondary_clock_config;
  logic [7:0] next_primary_clock_config;
  logic [7:0] next_secondary_clock_config;
  logic [7:0] next_rdata;

  always_comb begin
    next_primary_clock_config   = primary_clock_config;
    next_secondary_clock_config = secondary_clock_config;
    next_rdata                  = reg_rdata_out;
    if (reg_wr_in) begin
      unique case (reg_addr_in)
        ASR_PRIMARY_CLOCK_CONFIG_ADDR: begin
          next_primary_clock_config = reg_wdata_in;
        end
        ASR_SECONDARY_CLOCK_CONFIG_ADDR: begin
          next_secondary_clock_config = reg_wdata_in & ASR_SECONDARY_WRITE_MASK;
        end
        default: begin
          next_rdata = reg_rdata_out;
        end
      endcase
    end
    if (reg_rd_in) begin
      unique case (reg_addr_in)
        ASR_PRIMARY_CLOCK_CONFIG_ADDR: begin
          next_rdata = primary_clock_config;
        end
        ASR_SECONDARY_CLOCK_CONFIG_ADDR: begin
          next_rdata = secondary_clock_config & ASR_SECONDARY_WRITE_MASK;
        end
        default: begin
          next_rdata = ASR_UNMAPPED_READ;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (!rst_b_in) begin
      primary_clock_config   <= ASR_PRIMARY_CLOCK_CONFIG_RESET;
      secondary_clock_config <= ASR_SECONDARY_CLOCK_CONFIG_RESET;
      reg_rdata_out          <= 8'h00;
    end else begin
      primary_clock_config   <= next_primary_clock_config;
      secondary_clock_config <= next_secondary_clock_config;
      reg_rdata_out          <= next_rdata;
    end
  end

  // ==========================================================
  // Field decode
  logic [ASR_CODE_W-1:0] rate_code [ASR_NUM_IFACE];
  logic                  tol_sel   [ASR_NUM_IFACE];
  logic                  fsync     [ASR_NUM_IFACE];

  assign rate_code[ASR_PRIMARY]   = primary_clock_config[ASR_RATE_CODE_MSB:ASR_RATE_CODE_LSB];
  assign rate_code[ASR_SECONDARY] = secondary_clock_config[ASR_RATE_CODE_MSB:ASR_RATE_CODE_LSB];
  assign tol_sel[ASR_PRIMARY]     = primary_clock_config[ASR_TOL_SEL_BIT];
  assign tol_sel[ASR_SECONDARY]   = secondary_clock_config[ASR_TOL_SEL_BIT];
  assign fsync[ASR_PRIMARY]       = primary_fsync_in;
  assign fsync[ASR_SECONDARY]     = secondary_fsync_in;

  assign primary_rate_code_out            = rate_code[ASR_PRIMARY];
  assign secondary_rate_code_out          = rate_code[ASR_SECONDARY];
  assign primary_rate_tolerance_sel_out   = tol_sel[ASR_PRIMARY];
  assign secondary_rate_tolerance_sel_out = tol_sel[ASR_SECONDARY];
  // Custom mode hands every divider and mux select over to software
  assign auto_clk_cfg_en_out = ~primary_clock_config[ASR_CUSTOM_BIT];

  // ==========================================================
  // Measurement gate, shared so both interfaces sample the same window
  logic [31:0] gate_cnt;
  logic [31:0] next_gate_cnt;
  logic        gate;
  logic        next_gate;

  always_comb begin
    next_gate     = 1'b0;
    next_gate_cnt = gate_cnt + 32'h00000001;
    if (gate_cnt >= 32'(GATE_CYCLES - 1)) begin
      next_gate_cnt = 32'h00000000;
      next_gate     = 1'b1;
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (!rst_b_in) begin
      gate_cnt <= 32'h00000000;
      gate     <= 1'b0;
    end else begin
      gate_cnt <= next_gate_cnt;
      gate     <= next_gate;
    end
  end

  // ==========================================================
  // Auto detection: lowest code whose nominal rate lies within tolerance
  function automatic logic [ASR_CODE_W-1:0] asr_find_std(input logic [ASR_RATE_W-1:0] rate,
                                                         input logic wide);
    logic [ASR_CODE_W-1:0] hit;
    logic [ASR_RATE_W-1:0] diff;
    logic [27:0]           lhs;
    logic [27:0]           rhs;
    hit = ASR_CODE_AUTO;
    for (int k = ASR_NUM_CODES - 1; k >= 1; k--) begin
      diff = (rate >= ASR_NOM_RATE[k]) ? ASR_RATE_W'(rate - ASR_NOM_RATE[k])
                                       : ASR_RATE_W'(ASR_NOM_RATE[k] - rate);
      lhs  = 28'({8'h00, diff} * ASR_PCT_SCALE);
      rhs  = 28'({8'h00, ASR_NOM_RATE[k]} * (wide ? ASR_TOL_WIDE_PCT : ASR_TOL_NARROW_PCT));
      if (lhs <= rhs) begin
        hit = ASR_CODE_W'(k);
      end
    end
    return hit;
  endfunction

  // ==========================================================
  // Per-interface measurement and check
  logic [ASR_RATE_W-1:0] meas_rate [ASR_NUM_IFACE];
  logic                  meas_done [ASR_NUM_IFACE];
  logic [ASR_RATE_W-1:0] rate_q    [ASR_NUM_IFACE];
  logic [ASR_CODE_W-1:0] det_q     [ASR_NUM_IFACE];
  logic                  valid_q   [ASR_NUM_IFACE];
  logic                  invalid_q [ASR_NUM_IFACE];

  for (genvar i = 0; i < ASR_NUM_IFACE; i++) begin : g_iface
    logic [ASR_RATE_W-1:0] next_rate_q;
    logic [ASR_CODE_W-1:0] next_det_q;
    logic                  next_valid_q;
    logic                  next_invalid_q;
    logic [ASR_CODE_W-1:0] std_hit;

    asr_rate_meter #(
      .RATE_W     (ASR_RATE_W),
      .RATE_SCALE (RATE_SCALE)
    ) u_meter (
      .ref_clk_in (ref_clk_in),
      .rst_b_in   (rst_b_in),
      .fsync_in   (fsync[i]),
      .gate_in    (gate),
      .rate_out   (meas_rate[i]),
      .done_out   (meas_done[i])
    );

    assign std_hit = asr_find_std(meas_rate[i], tol_sel[i]);

    always_comb begin
      next_rate_q    = rate_q[i];
      next_det_q     = det_q[i];
      next_valid_q   = valid_q[i];
      next_invalid_q = invalid_q[i];
      if (meas_done[i]) begin
        next_rate_q  = meas_rate[i];
        next_valid_q = 1'b1;
        if (rate_code[i] == ASR_CODE_AUTO) begin
          next_det_q     = std_hit;
          next_invalid_q = (std_hit == ASR_CODE_AUTO);
        end else if (rate_code[i] > ASR_CODE_MAX) begin
          // Reserved codes have no window; flag rather than guess
          next_det_q     = ASR_CODE_AUTO;
          next_invalid_q = 1'b1;
        end else begin
          next_det_q     = rate_code[i];
          next_invalid_q = (meas_rate[i] < ASR_MIN_RATE[rate_code[i]]) ||
                           (meas_rate[i] > ASR_MAX_RATE[rate_code[i]]);
        end
      end
    end

    always_ff @(posedge ref_clk_in) begin
      if (!rst_b_in) begin
        rate_q[i]    <= '0;
        det_q[i]     <= ASR_CODE_AUTO;
        valid_q[i]   <= 1'b0;
        invalid_q[i] <= 1'b0;
      end else begin
        rate_q[i]    <= next_rate_q;
        det_q[i]     <= next_det_q;
        valid_q[i]   <= next_valid_q;
        invalid_q[i] <= next_invalid_q;
      end
    end
  end

  assign primary_measured_rate_out   = rate_q[ASR_PRIMARY];
  assign secondary_measured_rate_out = rate_q[ASR_SECONDARY];
  assign primary_detected_code_out   = det_q[ASR_PRIMARY];
  assign secondary_detected_code_out = det_q[ASR_SECONDARY];
  assign primary_rate_valid_out      = valid_q[ASR_PRIMARY];
  assign secondary_rate_valid_out    = valid_q[ASR_SECONDARY];
  assign primary_rate_invalid_out    = invalid_q[ASR_PRIMARY];
  assign secondary_rate_invalid_out  = invalid_q[ASR_SECONDARY];
endmodule
`default_nettype wire

/* dv/asr_sample_rate_config_checker.sv */
`timescale 1ns/10ps
`default_nettype none
module asr_sample_rate_config_checker (
  input wire logic        ref_clk_in,
  input wire logic        rst_b_in,
  input wire logic [7:0]  reg_addr_in,
  input wire logic        reg_wr_in,
  input wire logic [7:0]  reg_wdata_in,
  input wire logic        reg_rd_in,
  input wire logic [7:0]  reg_rdata_out,
  input wire logic [5:0]  primary_rate_code_out,
  input wire logic        primary_rate_tolerance_sel_out,
  input wire logic        auto_clk_cfg_en_out,
  input wire logic [5:0]  secondary_rate_code_out,
  input wire logic        secondary_rate_tolerance_sel_out,
  input wire logic [19:0] primary_measured_rate_out,
  input wire logic [5:0]  primary_detected_code_out,
  input wire logic        primary_rate_valid_out,
  input wire logic        primary_rate_invalid_out
);
  import asr_pkg::*;
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (!rst_b_in);
  logic wp;
  logic ws;
  logic rp;
  assign wp = reg_wr_in && reg_addr_in == ASR_PRIMARY_CLOCK_CONFIG_ADDR;
  assign ws = reg_wr_in && reg_addr_in == ASR_SECONDARY_CLOCK_CONFIG_ADDR;
  assign rp = reg_rd_in && !reg_wr_in && reg_addr_in == ASR_PRIMARY_CLOCK_CONFIG_ADDR;
  // ==========================================================
  // Field outputs follow register writes
  AST_PRI_CODE: assert property (wp |=> primary_rate_code_out == $past(reg_wdata_in[7:2]))
    else $error("primary rate code not loaded");
  AST_PRI_TOL: assert property (wp |=> primary_rate_tolerance_sel_out == $past(reg_wdata_in[1]))
    else $error("primary tolerance select not loaded");
  AST_AUTO_CLK: assert property (wp |=> auto_clk_cfg_en_out != $past(reg_wdata_in[0]))
    else $error("auto clock enable wrong");
  AST_SEC_CODE: assert property (ws |=> secondary_rate_code_out == $past(reg_wdata_in[7:2]))
    else $error("secondary rate code not loaded");
  AST_SEC_TOL: assert property (ws |=> secondary_rate_tolerance_sel_out == $past(reg_wdata_in[1]))
    else $error("secondary tolerance select not loaded");
  // ==========================================================
  // Read-back and reset state
  AST_SEC_BIT0: assert property (reg_rd_in && reg_addr_in == ASR_SECONDARY_CLOCK_CONFIG_ADDR |=> !reg_rdata_out[0])
    else $error("secondary reserved bit reads one");
  AST_RD_PRI: assert property (rp |=> reg_rdata_out ==
      $past({primary_rate_code_out, primary_rate_tolerance_sel_out, !auto_clk_cfg_en_out}))
    else $error("primary read-back differs from fields");
  AST_RESET: assert property ($rose(rst_b_in) |-> primary_rate_code_out == 6'h00 &&
      secondary_rate_code_out == 6'h00 && !primary_rate_tolerance_sel_out && !secondary_rate_tolerance_sel_out
      && auto_clk_cfg_en_out && !primary_rate_valid_out)
    else $error("outputs not at reset state");
  // Detected equal to programmed code means a fixed-rate verdict against its window
  AST_PRI_WIN: assert property (primary_rate_valid_out && primary_rate_code_out != 6'h00 &&
      primary_rate_code_out <= ASR_CODE_MAX && primary_detected_code_out == primary_rate_code_out |->
      primary_rate_invalid_out == (primary_measured_rate_out < ASR_MIN_RATE[primary_rate_code_out] ||
      primary_measured_rate_out > ASR_MAX_RATE[primary_rate_code_out]))
    else $error("fixed rate window verdict wrong");
endmodule
bind asr_sample_rate_config asr_sample_rate_config_checker i_asr_sample_rate_config_checker (.*);
`default_nettype wire

/* dv/asr_sample_rate_config_tb_top.sv */
`timescale 1ns/10ps
`default_nettype none
module asr_sample_rate_config_tb_top;
  import asr_pkg::*;
  // Short gate keeps the run small; rates are edge counts times SCALE
  localparam int GATE  = 2500;
  localparam int SCALE = 480;
  logic        ref_clk_in = 1'b0;
  logic        rst_b_in   = 1'b0;
  logic        wr = 1'b0, rd = 1'b0, pfs = 1'b0, sfs = 1'b0;
  logic [7:0]  addr = 8'h00, wdata = 8'h00, rdata;
  logic [5:0]  pcode, scode, pdet, sdet;
  logic [19:0] pm, sm;
  logic        ptol, stol, aclk, pval, sval, pinv, sinv;
  int          fail_count = 0, cmp_count = 0, cyc = 0, pp = 0, sp = 0, pc = 0, sc = 0;

  asr_sample_rate_config #(.GATE_CYCLES(GATE), .RATE_SCALE(SCALE)) i_asr_sample_rate_config (
    .ref_clk_in(ref_clk_in), .rst_b_in(rst_b_in), .reg_addr_in(addr), .reg_wr_in(wr),
    .reg_wdata_in(wdata), .reg_rd_in(rd), .reg_rdata_out(rdata), .primary_fsync_in(pfs),
    .secondary_fsync_in(sfs), .primary_rate_code_out(pcode), .primary_rate_tolerance_sel_out(ptol),
    .auto_clk_cfg_en_out(aclk), .secondary_rate_code_out(scode), .secondary_rate_tolerance_sel_out(stol),
    .primary_measured_rate_out(pm), .secondary_measured_rate_out(sm), .primary_detected_code_out(pdet),
    .secondary_detected_code_out(sdet), .primary_rate_valid_out(pval), .secondary_rate_valid_out(sval),
    .primary_rate_invalid_out(pinv), .secondary_rate_invalid_out(sinv));

  initial begin
    forever #20 ref_clk_in = ~ref_clk_in;
  end

  // ==========================================================
  // Frame syncs: a period dividing GATE gives an exact edge count per window
  always @(negedge ref_clk_in) begin
    pc = (pp == 0) ? 0 : (pc + 1) % pp;
    sc = (sp == 0) ? 0 : (sc + 1) % sp;
    pfs = pp != 0 && pc < pp / 2;
    sfs = sp != 0 && sc < sp / 2;
  end

  always @(posedge ref_clk_in) begin
    cyc++;
    if (cyc == 40000) begin
      fail_count++;
      complete_run();
    end
  end

  // ==========================================================
  // Access tasks and comparison
  task automatic complete_run;
    $display("Comparisons %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic cmp(input string n, input logic [19:0] e, input logic [19:0] g);
    cmp_count++;
    if (g !== e) begin
      fail_count++;
      $display("Error %s expected %0h seen %0h", n, e, g);
    end
  endtask

  task automatic cmp_code(input string n, input logic [5:0] e, input logic [5:0] g);
    cmp(n, {14'h0000, e}, {14'h0000, g});
  endtask

  task automatic cmp_bit(input string n, input logic e, input logic g);
    cmp(n, {19'h00000, e}, {19'h00000, g});
  endtask

  task automatic cmp_byte(input string n, input logic [7:0] e, input logic [7:0] g);
    cmp(n, {12'h000, e}, {12'h000, g});
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(negedge ref_clk_in);
    addr = a;
    wdata = d;
    wr = 1'b1;
    @(negedge ref_clk_in);
    wr = 1'b0;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    @(negedge ref_clk_in);
    addr = a;
    rd = 1'b1;
    @(negedge ref_clk_in);
    rd = 1'b0;
    @(negedge ref_clk_in);
    cmp_byte("read data", e, rdata);
  endtask

  // One new window fully inside the new settings completes within two gates
  task automatic step(input logic [7:0] p, input logic [7:0] s, input int np, input int ns,
                      input int pme, input logic [5:0] pde, input logic pie,
                      input int sme, input logic [5:0] sde, input logic sie);
    wr_reg(ASR_PRIMARY_CLOCK_CONFIG_ADDR, p);
    wr_reg(ASR_SECONDARY_CLOCK_CONFIG_ADDR, s);
    pp = np;
    sp = ns;
    repeat (2 * GATE + 10) @(negedge ref_clk_in);
    cmp("primary rate", 20'(pme), pm);
    cmp_code("primary detected", pde, pdet);
    cmp_bit("primary invalid", pie, pinv);
    cmp_bit("primary valid", 1'b1, pval);
    cmp("secondary rate", 20'(sme), sm);
    cmp_code("secondary detected", sde, sdet);
    cmp_bit("secondary invalid", sie, sinv);
    cmp_bit("secondary valid", 1'b1, sval);
  endtask

  initial begin
    repeat (5) @(negedge ref_clk_in);
    rst_b_in = 1'b1;
    cmp_bit("auto clock", 1'b1, aclk);
    rd_chk(ASR_PRIMARY_CLOCK_CONFIG_ADDR, 8'h00);
    rd_chk(ASR_SECONDARY_CLOCK_CONFIG_ADDR, 8'h00);
    wr_reg(ASR_PRIMARY_CLOCK_CONFIG_ADDR, 8'h52);
    cmp_code("primary code", 6'h14, pcode);
    cmp_bit("primary tolerance", 1'b1, ptol);
    rd_chk(ASR_PRIMARY_CLOCK_CONFIG_ADDR, 8'h52);
    wr_reg(ASR_PRIMARY_CLOCK_CONFIG_ADDR, 8'h01);
    cmp_bit("auto clock", 1'b0, aclk);
    rd_chk(ASR_PRIMARY_CLOCK_CONFIG_ADDR, 8'h01);
    // Software keeps the reserved bit at zero and uses only legal codes
    wr_reg(ASR_SECONDARY_CLOCK_CONFIG_ADDR, 8'hA2);
    cmp_code("secondary code", 6'h28, scode);
    cmp_bit("secondary tolerance", 1'b1, stol);
    rd_chk(ASR_SECONDARY_CLOCK_CONFIG_ADDR, 8'hA2);
    wr_reg(8'h34, 8'hAA);
    rd_chk(8'h34, ASR_UNMAPPED_READ);
    rd_chk(ASR_SECONDARY_CLOCK_CONFIG_ADDR, 8'hA2);
    // Legal codes only: fixed in and out of window, auto at both tolerances
    step(8'h50, 8'h64, 25, 25, 100 * SCALE, 6'h14, 1'b0, 100 * SCALE, 6'h19, 1'b1);
    step(8'h50, 8'h64, 20, 50, 125 * SCALE, 6'h14, 1'b1, 50 * SCALE, 6'h19, 1'b0);
    step(8'h00, 8'h02, 4, 4, 625 * SCALE, 6'h00, 1'b1, 625 * SCALE, 6'h07, 1'b0);
    step(8'h02, 8'h00, 4, 50, 625 * SCALE, 6'h07, 1'b0, 50 * SCALE, 6'h19, 1'b0);
    step(8'h01, 8'h00, 50, 0, 50 * SCALE, 6'h19, 1'b0, 0, 6'h00, 1'b1);
    complete_run();
  end
endmodule
`default_nettype wire
